/* File: rtl/bram_pkg.sv */
// Purpose: shared constants and types of the block ram
// Assumes: one 512 x 36 storage word array, four 9-bit lanes
// Notes: widths and depths fixed
package bram_pkg;
  // ***********************************
  // geometry
  // ***********************************
  localparam int WORDS = 512;
  localparam int WORD_W = 36;
  localparam int ADDR_W = 14;
  localparam int WORD_AW = 9;
  localparam int OFF_W = 6;
  localparam int ECC_DW = 32;
  localparam int ECC_CW = 7;
  localparam int ECC_POS = 38;
  localparam int PTR_W = 10;
  localparam logic [9:0] FIFO_DEPTH = 10'h200;
  // ***********************************
  // field masks and reset values
  // ***********************************
  localparam logic [35:0] FMASK_1 = 36'h0_0000_0001;
  localparam logic [35:0] FMASK_2 = 36'h0_0000_0003;
  localparam logic [35:0] FMASK_4 = 36'h0_0000_000f;
  localparam logic [35:0] FMASK_9 = 36'h0_0000_01ff;
  localparam logic [35:0] FMASK_18 = 36'h0_0003_ffff;
  localparam logic [35:0] FMASK_36 = 36'hf_ffff_ffff;
  localparam logic [35:0] WORD_RST = 36'h0_0000_0000;
  localparam logic [1:0] RST_SYNC_CLR = 2'h0;
  localparam logic [9:0] PTR_RST = 10'h000;
  localparam logic FLAG_EMPTY_RST = 1'b1;
  localparam logic FLAG_FULL_RST = 1'b0;
  // ***********************************
  // modes and widths
  // ***********************************
  typedef enum logic [2:0] {MODE_SINGLE, MODE_TRUE_DUAL, MODE_PSEUDO_DUAL, MODE_ROM, MODE_FIFO} bram_mode_e;
  typedef enum logic [2:0] {WIDTH_1, WIDTH_2, WIDTH_4, WIDTH_9, WIDTH_18, WIDTH_36} bram_width_e;
endpackage : bram_pkg

/* File: rtl/bram_ecc.sv */
// Purpose: secded encoder and decoder for 32-bit words
// Assumes: 6 hamming bits plus one overall parity bit
// Notes: purely combinational
`timescale 1ns/100ps
module bram_ecc (
  // encoder
  input wire logic [31:0] enc_data,
  output logic [6:0] enc_check,
  // decoder
  input wire logic [31:0] dec_data,
  input wire logic [6:0] dec_check,
  output logic [31:0] dec_fixed,
  output logic dec_single,
  output logic dec_double
);
  // ***********************************
  // check bit generation
  // ***********************************
  always_comb begin : encode
    int j;
    j = 0;
    enc_check = 7'h00;
    for (int p = 1; p <= bram_pkg::ECC_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < 6; i++) begin
          if (p[i]) enc_check[i] = enc_check[i] ^ enc_data[j];
        end
        j++;
      end
    end
    enc_check[6] = (^enc_data) ^ (^enc_check[5:0]);
  end
  // ***********************************
  // syndrome and correction
  // ***********************************
  always_comb begin : decode
    int j;
    logic [5:0] syn;
    logic bad;
    j = 0;
    syn = dec_check[5:0];
    bad = (^dec_data) ^ (^dec_check);
    for (int p = 1; p <= bram_pkg::ECC_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < 6; i++) begin
          if (p[i]) syn[i] = syn[i] ^ dec_data[j];
        end
        j++;
      end
    end
    j = 0;
    dec_fixed = dec_data;
    for (int p = 1; p <= bram_pkg::ECC_POS; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (bad && syn == 6'(p)) dec_fixed[j] = ~dec_data[j];
        j++;
      end
    end
    dec_single = bad;
    dec_double = ~bad & (syn != 6'h00);
  end
endmodule : bram_ecc

/* File: rtl/bram_fifo_ctrl.sv */
// Purpose: pointers and flags of the buffer mode
// Assumes: 512 words of 36 bits
// Notes: refused push or pop leaves pointers alone
`timescale 1ns/100ps
module bram_fifo_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests
  input wire logic push,
  input wire logic pop,
  input wire logic [9:0] af_level,
  input wire logic [9:0] ae_level,
  // state
  output logic push_ok,
  output logic pop_ok,
  output logic [8:0] wr_word,
  output logic [8:0] rd_word,
  output logic [9:0] count,
  output logic full,
  output logic empty,
  output logic almost_full,
  output logic almost_empty
);
  logic [9:0] wr_ptr;
  logic [9:0] rd_ptr;
  logic [9:0] next_wr;
  logic [9:0] next_rd;
  logic [9:0] next_count;
  assign push_ok = push & ~full;
  assign pop_ok = pop & ~empty;
  assign next_wr = wr_ptr + {9'h000, push_ok};
  assign next_rd = rd_ptr + {9'h000, pop_ok};
  assign next_count = next_wr - next_rd;
  assign wr_word = wr_ptr[8:0];
  assign rd_word = rd_ptr[8:0];
  assign count = wr_ptr - rd_ptr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= bram_pkg::PTR_RST;
      rd_ptr <= bram_pkg::PTR_RST;
    end else begin
      wr_ptr <= next_wr;
      rd_ptr <= next_rd;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full <= bram_pkg::FLAG_FULL_RST;
      almost_full <= bram_pkg::FLAG_FULL_RST;
      empty <= bram_pkg::FLAG_EMPTY_RST;
      almost_empty <= bram_pkg::FLAG_EMPTY_RST;
    end else begin
      full <= next_count == bram_pkg::FIFO_DEPTH;
      empty <= next_count == bram_pkg::PTR_RST;
      almost_full <= next_count >= af_level;
      almost_empty <= next_count <= ae_level;
    end
  end
endmodule : bram_fifo_ctrl

/* File: rtl/bram_top.sv */
// Purpose: two-port 18 kb block ram with buffer mode and ecc
// Assumes: both ports and all control on core_clk
// Notes: preload port used only while ports idle
`timescale 1ns/100ps
module bram_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic global_reset_n,
  // configuration
  input wire bram_pkg::bram_mode_e mode,
  input wire bram_pkg::bram_width_e port_a_width,
  input wire bram_pkg::bram_width_e port_b_width,
  input wire logic ecc_enable,
  input wire logic output_pipe_a,
  input wire logic output_pipe_b,
  input wire logic reset_async,
  // port a
  input wire logic a_en,
  input wire logic a_we,
  input wire logic [13:0] a_addr,
  input wire logic [35:0] a_wdata,
  input wire logic [3:0] a_byte_en,
  input wire logic port_a_output_reset,
  output logic [35:0] a_rdata,
  output logic a_single_err,
  output logic a_double_err,
  // port b
  input wire logic b_en,
  input wire logic b_we,
  input wire logic [13:0] b_addr,
  input wire logic [35:0] b_wdata,
  input wire logic [3:0] b_byte_en,
  input wire logic port_b_output_reset,
  output logic [35:0] b_rdata,
  output logic b_single_err,
  output logic b_double_err,
  // buffer levels and flags
  input wire logic [9:0] almost_full_level,
  input wire logic [9:0] almost_empty_level,
  output logic fifo_full,
  output logic fifo_almost_full,
  output logic fifo_empty,
  output logic fifo_almost_empty,
  output logic [9:0] fifo_count,
  // preload
  input wire logic init_we,
  input wire logic [8:0] init_addr,
  input wire logic [35:0] init_data
);
  // ***********************************
  // reset release
  // ***********************************
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= bram_pkg::RST_SYNC_CLR;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];
  // ***********************************
  // storage
  // ***********************************
  logic [35:0] mem [bram_pkg::WORDS];
  logic [6:0] chk_mem [bram_pkg::WORDS];
  // ***********************************
  // per-port gathering
  // ***********************************
  logic [1:0] en_in;
  logic [1:0] we_in;
  logic [1:0] out_rst_in;
  logic [1:0] pipe_in;
  logic [13:0] addr_in [2];
  logic [35:0] wdata_in [2];
  logic [3:0] be_in [2];
  bram_pkg::bram_width_e w_in [2];
  logic [35:0] rdata_o [2];
  logic [1:0] serr_o;
  logic [1:0] derr_o;
  assign en_in = {b_en, a_en};
  assign we_in = {b_we, a_we};
  assign out_rst_in = {port_b_output_reset, port_a_output_reset};
  assign pipe_in = {output_pipe_b, output_pipe_a};
  assign addr_in[0] = a_addr;
  assign addr_in[1] = b_addr;
  assign wdata_in[0] = a_wdata;
  assign wdata_in[1] = b_wdata;
  assign be_in[0] = a_byte_en;
  assign be_in[1] = b_byte_en;
  assign w_in[0] = port_a_width;
  assign w_in[1] = port_b_width;
  assign a_rdata = rdata_o[0];
  assign b_rdata = rdata_o[1];
  assign a_single_err = serr_o[0];
  assign b_single_err = serr_o[1];
  assign a_double_err = derr_o[0];
  assign b_double_err = derr_o[1];
  // ***********************************
  // buffer counters
  // ***********************************
  logic push_ok, pop_ok, is_fifo;
  logic [8:0] fifo_wr_word, fifo_rd_word;
  assign is_fifo = mode == bram_pkg::MODE_FIFO;
  bram_fifo_ctrl u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .push(is_fifo & a_en),
    .pop(is_fifo & b_en),
    .af_level(almost_full_level),
    .ae_level(almost_empty_level),
    .push_ok(push_ok),
    .pop_ok(pop_ok),
    .wr_word(fifo_wr_word),
    .rd_word(fifo_rd_word),
    .count(fifo_count),
    .full(fifo_full),
    .empty(fifo_empty),
    .almost_full(fifo_almost_full),
    .almost_empty(fifo_almost_empty)
  );
  // ***********************************
  // mode decode
  // ***********************************
  logic [1:0] wr_req;
  logic [1:0] rd_req;
  always_comb begin
    wr_req = 2'h0;
    rd_req = 2'h0;
    unique case (mode)
      bram_pkg::MODE_SINGLE: begin
        wr_req = {1'b0, a_en & a_we};
        rd_req = {1'b0, a_en & ~a_we};
      end
      bram_pkg::MODE_TRUE_DUAL: begin
        wr_req = en_in & we_in;
        rd_req = en_in & ~we_in;
      end
      bram_pkg::MODE_PSEUDO_DUAL: begin
        wr_req = {1'b0, a_en & a_we};
        rd_req = {b_en, 1'b0};
      end
      bram_pkg::MODE_ROM: begin
        wr_req = 2'h0;
        rd_req = en_in;
      end
      bram_pkg::MODE_FIFO: begin
        wr_req = {1'b0, push_ok};
        rd_req = {pop_ok, 1'b0};
      end
      default: wr_req = 2'h0;
    endcase
  end
  // ***********************************
  // address mapping
  // ***********************************
  function automatic logic [5:0] lane_off(input logic [1:0] lane);
    lane_off = {1'b0, lane, 3'b000} + {4'h0, lane};
  endfunction : lane_off
  function automatic logic [14:0] map_addr(input bram_pkg::bram_width_e w, input logic [13:0] a);
    logic [8:0] wd;
    logic [5:0] off;
    wd = a[8:0];
    off = 6'h00;
    unique case (w)
      bram_pkg::WIDTH_1: begin
        wd = a[13:5];
        off = lane_off(a[4:3]) + {3'h0, a[2:0]};
      end
      bram_pkg::WIDTH_2: begin
        wd = a[12:4];
        off = lane_off(a[3:2]) + {3'h0, a[1:0], 1'b0};
      end
      bram_pkg::WIDTH_4: begin
        wd = a[11:3];
        off = lane_off(a[2:1]) + {3'h0, a[0], 2'b00};
      end
      bram_pkg::WIDTH_9: begin
        wd = a[10:2];
        off = lane_off(a[1:0]);
      end
      bram_pkg::WIDTH_18: begin
        wd = a[9:1];
        off = a[0] ? 6'h12 : 6'h00;
      end
      bram_pkg::WIDTH_36: begin
        wd = a[8:0];
        off = 6'h00;
      end
      default: off = 6'h00;
    endcase
    map_addr = {wd, off};
  endfunction : map_addr
  function automatic logic [35:0] field_mask(input bram_pkg::bram_width_e w);
    unique case (w)
      bram_pkg::WIDTH_1: field_mask = bram_pkg::FMASK_1;
      bram_pkg::WIDTH_2: field_mask = bram_pkg::FMASK_2;
      bram_pkg::WIDTH_4: field_mask = bram_pkg::FMASK_4;
      bram_pkg::WIDTH_9: field_mask = bram_pkg::FMASK_9;
      bram_pkg::WIDTH_18: field_mask = bram_pkg::FMASK_18;
      default: field_mask = bram_pkg::FMASK_36;
    endcase
  endfunction : field_mask
  // ***********************************
  // ports
  // ***********************************
  logic [1:0] wr_r;
  logic [1:0] rd_r;
  logic [1:0] ecc_r;
  logic [8:0] word_r [2];
  logic [35:0] wmask_r [2];
  logic [35:0] wdata_r [2];
  logic [6:0] chk [2];
  for (genvar gi = 0; gi < 2; gi++) begin : g_port
    bram_pkg::bram_width_e w_eff;
    logic [8:0] word;
    logic [5:0] off;
    logic [35:0] fmask;
    logic [35:0] lmask;
    logic [5:0] off_r;
    logic [35:0] fmask_r;
    logic [35:0] raw;
    logic [31:0] fixed;
    logic single, double;
    logic [35:0] rd_val;
    logic clr, arst, srst;
    logic [35:0] latch_q;
    logic latch_s, latch_d;
    logic [35:0] pipe_q;
    logic pipe_s, pipe_d;
    always_comb begin
      if (ecc_enable || is_fifo) begin
        w_eff = bram_pkg::WIDTH_36;
      end else if (mode == bram_pkg::MODE_TRUE_DUAL && w_in[gi] == bram_pkg::WIDTH_36) begin
        w_eff = bram_pkg::WIDTH_18;
      end else begin
        w_eff = w_in[gi];
      end
      {word, off} = map_addr(w_eff, addr_in[gi]);
      if (is_fifo) begin
        word = (gi == 0) ? fifo_wr_word : fifo_rd_word;
        off = 6'h00;
      end
      fmask = field_mask(w_eff);
      if (ecc_enable) begin
        fmask = {4'h0, {bram_pkg::ECC_DW{1'b1}}};
        lmask = bram_pkg::FMASK_36;
      end else if (w_eff == bram_pkg::WIDTH_36) begin
        lmask = {{9{be_in[gi][3]}}, {9{be_in[gi][2]}}, {9{be_in[gi][1]}}, {9{be_in[gi][0]}}};
      end else if (w_eff == bram_pkg::WIDTH_18) begin
        lmask = {18'h0_0000, {9{be_in[gi][1]}}, {9{be_in[gi][0]}}};
      end else begin
        lmask = bram_pkg::FMASK_36;
      end
    end
    // input registers
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        wr_r[gi] <= 1'b0;
        rd_r[gi] <= 1'b0;
        ecc_r[gi] <= 1'b0;
        word_r[gi] <= 9'h000;
        off_r <= 6'h00;
        fmask_r <= bram_pkg::WORD_RST;
        wmask_r[gi] <= bram_pkg::WORD_RST;
        wdata_r[gi] <= bram_pkg::WORD_RST;
      end else begin
        wr_r[gi] <= wr_req[gi];
        rd_r[gi] <= rd_req[gi];
        ecc_r[gi] <= ecc_enable;
        word_r[gi] <= word;
        off_r <= off;
        fmask_r <= fmask;
        wmask_r[gi] <= (fmask & lmask) << off;
        wdata_r[gi] <= (wdata_in[gi] & fmask) << off;
      end
    end
    assign raw = mem[word_r[gi]];
    bram_ecc u_ecc (
      .enc_data((gi == 0 && init_we) ? init_data[31:0] : wdata_r[gi][31:0]),
      .enc_check(chk[gi]),
      .dec_data(raw[31:0]),
      .dec_check(chk_mem[word_r[gi]]),
      .dec_fixed(fixed),
      .dec_single(single),
      .dec_double(double)
    );
    assign rd_val = ecc_r[gi] ? {4'h0, fixed} : ((raw >> off_r) & fmask_r);
    // output resets
    assign clr = out_rst_in[gi] | ~global_reset_n;
    assign arst = ~rst_n | (clr & reset_async);
    assign srst = clr & ~reset_async;
    // output latch
    always_ff @(posedge core_clk or posedge arst) begin
      if (arst) begin
        latch_q <= bram_pkg::WORD_RST;
        latch_s <= 1'b0;
        latch_d <= 1'b0;
      end else if (srst) begin
        latch_q <= bram_pkg::WORD_RST;
        latch_s <= 1'b0;
        latch_d <= 1'b0;
      end else if (rd_r[gi]) begin
        latch_q <= rd_val;
        latch_s <= ecc_r[gi] & single;
        latch_d <= ecc_r[gi] & double;
      end
    end
    // output pipeline
    always_ff @(posedge core_clk or posedge arst) begin
      if (arst) begin
        pipe_q <= bram_pkg::WORD_RST;
        pipe_s <= 1'b0;
        pipe_d <= 1'b0;
      end else if (srst) begin
        pipe_q <= bram_pkg::WORD_RST;
        pipe_s <= 1'b0;
        pipe_d <= 1'b0;
      end else begin
        pipe_q <= latch_q;
        pipe_s <= latch_s;
        pipe_d <= latch_d;
      end
    end
    assign rdata_o[gi] = pipe_in[gi] ? pipe_q : latch_q;
    assign serr_o[gi] = pipe_in[gi] ? pipe_s : latch_s;
    assign derr_o[gi] = pipe_in[gi] ? pipe_d : latch_d;
  end
  // ***********************************
  // array writes
  // ***********************************
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (wr_r[i]) begin
        mem[word_r[i]] <= (mem[word_r[i]] & ~wmask_r[i]) | (wdata_r[i] & wmask_r[i]);
        if (ecc_r[i]) chk_mem[word_r[i]] <= chk[i];
      end
    end
    if (init_we) begin
      mem[init_addr] <= init_data;
      chk_mem[init_addr] <= chk[0];
    end
  end
endmodule : bram_top

/* File: verif/bram_props.sv */
// Purpose: port assertions of the block ram
// Assumes: one clock, buffer levels held static
// Notes: bound to bram_top
`timescale 1ns/100ps
module bram_props (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic global_reset_n,
  input wire logic port_a_output_reset,
  input wire logic port_b_output_reset,
  // control
  input wire bram_pkg::bram_mode_e mode,
  input wire logic a_en,
  input wire logic b_en,
  input wire logic [9:0] almost_full_level,
  input wire logic [9:0] almost_empty_level,
  // outputs
  input wire logic [35:0] a_rdata,
  input wire logic [35:0] b_rdata,
  input wire logic a_single_err,
  input wire logic a_double_err,
  input wire logic fifo_full,
  input wire logic fifo_almost_full,
  input wire logic fifo_empty,
  input wire logic fifo_almost_empty,
  input wire logic [9:0] fifo_count
);
  // ****************
  // properties
  // ****************
  default clocking dck @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_empty; fifo_empty == (fifo_count == 10'h000); endproperty
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  property p_full; fifo_full == (fifo_count == 10'h200); endproperty
  a_full: assert property (p_full) else $error("full flag wrong");
  property p_af; fifo_almost_full == (fifo_count >= almost_full_level); endproperty
  a_af: assert property (p_af) else $error("almost full wrong");
  property p_ae; fifo_almost_empty == (fifo_count <= almost_empty_level); endproperty
  a_ae: assert property (p_ae) else $error("almost empty wrong");
  property p_push;
    mode == bram_pkg::MODE_FIFO && a_en && !b_en && !fifo_full |=> fifo_count == $past(fifo_count) + 10'h001;
  endproperty
  a_push: assert property (p_push) else $error("push count wrong");
  property p_pop;
    mode == bram_pkg::MODE_FIFO && b_en && !a_en && !fifo_empty |=> fifo_count == $past(fifo_count) - 10'h001;
  endproperty
  a_pop: assert property (p_pop) else $error("pop count wrong");
  property p_refuse;
    mode == bram_pkg::MODE_FIFO && a_en && !b_en && fifo_full |=> fifo_full && $stable(fifo_count);
  endproperty
  a_refuse: assert property (p_refuse) else $error("push accepted when full");
  property p_lrst; port_a_output_reset |=> a_rdata == 36'h0_0000_0000; endproperty
  a_lrst: assert property (p_lrst) else $error("port a not cleared");
  property p_own;
    port_a_output_reset && !port_b_output_reset && global_reset_n && !b_en && !$past(b_en) && !$past(b_en, 2)
      |=> $stable(b_rdata);
  endproperty
  a_own: assert property (p_own) else $error("port b disturbed");
  property p_grst; !global_reset_n |=> a_rdata == 36'h0_0000_0000 && b_rdata == 36'h0_0000_0000; endproperty
  a_grst: assert property (p_grst) else $error("global clear missed");
  property p_err; !(a_single_err && a_double_err); endproperty
  a_err: assert property (p_err) else $error("both error flags");
  c_full: cover property (fifo_full);
  c_single: cover property (a_single_err);
  c_double: cover property (a_double_err);
endmodule : bram_props

bind bram_top bram_props bram_props_inst (.core_clk(core_clk), .rst_b(rst_b), .global_reset_n(global_reset_n),
  .port_a_output_reset(port_a_output_reset), .port_b_output_reset(port_b_output_reset), .mode(mode),
  .a_en(a_en), .b_en(b_en), .almost_full_level(almost_full_level), .almost_empty_level(almost_empty_level),
  .a_rdata(a_rdata), .b_rdata(b_rdata), .a_single_err(a_single_err), .a_double_err(a_double_err),
  .fifo_full(fifo_full), .fifo_almost_full(fifo_almost_full), .fifo_empty(fifo_empty),
  .fifo_almost_empty(fifo_almost_empty), .fifo_count(fifo_count));

/* File: verif/bram_fabric_user.sv */
// Purpose: fabric logic that pushes and pops the buffer
// Assumes: flags registered by the block
// Notes: ignore_flags lets a scenario overrun on purpose
`timescale 1ns/100ps
module bram_fabric_user (
  // scenario requests
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic ignore_flags,
  // buffer flags
  input wire logic fifo_full,
  input wire logic fifo_empty,
  // enables
  output logic push_en,
  output logic pop_en
);
  // ****************
  // gating
  // ****************
  assign push_en = push_req && (ignore_flags || !fifo_full);
  assign pop_en = pop_req && (ignore_flags || !fifo_empty);
endmodule : bram_fabric_user

/* File: verif/testbench.sv */
// Purpose: self-checking bench of the block ram
// Assumes: inputs driven on the falling edge
// Notes: each scenario is one task
`timescale 1ns/100ps
module testbench;
  // ****************
  // signals
  // ****************
  logic core_clk = 1'b0;
  logic rst_b, global_reset_n, ecc_enable, output_pipe_a, output_pipe_b, reset_async;
  bram_pkg::bram_mode_e mode;
  bram_pkg::bram_width_e port_a_width, port_b_width;
  logic tb_a_en, b_req, a_we, b_we, port_a_output_reset, port_b_output_reset, init_we;
  logic push_req, pop_req, ignore_flags, push_en, pop_en, a_en, b_en;
  logic [13:0] a_addr, b_addr;
  logic [35:0] a_wdata, b_wdata, init_data, a_rdata, b_rdata, q;
  logic [3:0] a_byte_en, b_byte_en;
  logic [8:0] init_addr;
  logic [9:0] fifo_count;
  logic a_single_err, a_double_err, b_single_err, b_double_err;
  logic fifo_full, fifo_almost_full, fifo_empty, fifo_almost_empty;
  int mismatches = 0;
  int samples_checked = 0;
  always #4 core_clk = ~core_clk;
  assign a_en = tb_a_en | push_en;
  assign b_en = b_req | pop_en;
  bram_top bram_top_inst (.core_clk(core_clk), .rst_b(rst_b), .global_reset_n(global_reset_n), .mode(mode),
    .port_a_width(port_a_width), .port_b_width(port_b_width), .ecc_enable(ecc_enable),
    .output_pipe_a(output_pipe_a), .output_pipe_b(output_pipe_b), .reset_async(reset_async),
    .a_en(a_en), .a_we(a_we), .a_addr(a_addr), .a_wdata(a_wdata), .a_byte_en(a_byte_en),
    .port_a_output_reset(port_a_output_reset), .a_rdata(a_rdata), .a_single_err(a_single_err),
    .a_double_err(a_double_err), .b_en(b_en), .b_we(b_we), .b_addr(b_addr), .b_wdata(b_wdata),
    .b_byte_en(b_byte_en), .port_b_output_reset(port_b_output_reset), .b_rdata(b_rdata),
    .b_single_err(b_single_err), .b_double_err(b_double_err), .almost_full_level(10'h1f0),
    .almost_empty_level(10'h004), .fifo_full(fifo_full), .fifo_almost_full(fifo_almost_full),
    .fifo_empty(fifo_empty), .fifo_almost_empty(fifo_almost_empty), .fifo_count(fifo_count),
    .init_we(init_we), .init_addr(init_addr), .init_data(init_data));
  bram_fabric_user bram_fabric_user_inst (.push_req(push_req), .pop_req(pop_req), .ignore_flags(ignore_flags),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty), .push_en(push_en), .pop_en(pop_en));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input bit p, input logic we, input logic [13:0] ad, input logic [35:0] d);
    if (p) begin
      b_req = 1'b1;
      b_we = we;
      b_addr = ad;
      b_wdata = d;
    end else begin
      tb_a_en = 1'b1;
      a_we = we;
      a_addr = ad;
      a_wdata = d;
    end
    @(negedge core_clk);
  endtask : acc
  task automatic rel;
    tb_a_en = 1'b0;
    b_req = 1'b0;
    a_we = 1'b0;
    b_we = 1'b0;
    @(negedge core_clk);
  endtask : rel
  task automatic rd(input bit p, input logic [13:0] ad, output logic [35:0] v);
    acc(p, 1'b0, ad, 36'h0_0000_0000);
    rel;
    repeat (p ? output_pipe_b : output_pipe_a) @(negedge core_clk);
    v = p ? b_rdata : a_rdata;
  endtask : rd
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // ****************
  // scenarios
  // ****************
  task automatic s_bytes;
    output_pipe_a = 1'b1;
    acc(1'b0, 1'b1, 14'h0004, 36'h1_2345_6789);
    a_byte_en = 4'h2;
    acc(1'b0, 1'b1, 14'h0004, 36'h0_0000_0000);
    rel;
    rd(1'b0, 14'h0004, q);
    chk(q, 36'h1_2344_0189);
  endtask : s_bytes
  task automatic s_order;
    mode = bram_pkg::MODE_PSEUDO_DUAL;
    port_b_width = bram_pkg::WIDTH_1;
    a_byte_en = 4'hf;
    acc(1'b0, 1'b1, 14'h0000, 36'h0_0000_0205);
    rel;
    rd(1'b1, 14'h0000, q);
    chk(q, 36'h0_0000_0001);
    rd(1'b1, 14'h0001, q);
    chk(q, 36'h0_0000_0000);
    rd(1'b1, 14'h0008, q);
    chk(q, 36'h0_0000_0001);
    port_b_width = bram_pkg::WIDTH_2;
    rd(1'b1, 14'h0001, q);
    chk(q, 36'h0_0000_0001);
    port_b_width = bram_pkg::WIDTH_4;
    rd(1'b1, 14'h0000, q);
    chk(q, 36'h0_0000_0005);
    port_b_width = bram_pkg::WIDTH_9;
    rd(1'b1, 14'h0001, q);
    chk(q, 36'h0_0000_0001);
  endtask : s_order
  task automatic s_ecc(input logic [31:0] bad, input logic [35:0] flags);
    mode = bram_pkg::MODE_SINGLE;
    ecc_enable = 1'b1;
    acc(1'b0, 1'b1, 14'h0005, 36'h0_1357_9bdf);
    rel;
    ecc_enable = 1'b0;
    acc(1'b0, 1'b1, 14'h0005, {4'h0, bad});
    rel;
    ecc_enable = 1'b1;
    rd(1'b0, 14'h0005, q);
    chk(q, flags[0] ? {4'h0, bad} : 36'h0_1357_9bdf);
    chk({34'h0, a_single_err, a_double_err}, flags);
    mode = bram_pkg::MODE_TRUE_DUAL;
    rd(1'b1, 14'h0005, q);
    chk({34'h0, b_single_err, b_double_err}, flags);
    ecc_enable = 1'b0;
  endtask : s_ecc
  task automatic s_rom;
    init_addr = 9'h007;
    init_data = 36'h9_8765_4321;
    init_we = 1'b1;
    @(negedge core_clk);
    init_we = 1'b0;
    mode = bram_pkg::MODE_ROM;
    acc(1'b0, 1'b1, 14'h0007, 36'h0_0000_0000);
    rel;
    rd(1'b0, 14'h0007, q);
    chk(q, 36'h9_8765_4321);
  endtask : s_rom
  task automatic s_resets;
    mode = bram_pkg::MODE_TRUE_DUAL;
    port_a_width = bram_pkg::WIDTH_18;
    port_b_width = bram_pkg::WIDTH_18;
    output_pipe_b = 1'b1;
    a_byte_en = 4'h3;
    acc(1'b0, 1'b1, 14'h0003, 36'h0_0003_1234);
    rel;
    rd(1'b0, 14'h0003, q);
    chk(q, 36'h0_0003_1234);
    rd(1'b1, 14'h0003, q);
    chk(q, 36'h0_0003_1234);
    reset_async = 1'b1;
    port_a_output_reset = 1'b1;
    #1;
    chk(a_rdata, 36'h0_0000_0000);
    chk(b_rdata, 36'h0_0003_1234);
    @(negedge core_clk);
    port_a_output_reset = 1'b0;
    reset_async = 1'b0;
    global_reset_n = 1'b0;
    #1;
    chk(b_rdata, 36'h0_0003_1234);
    @(negedge core_clk);
    chk(b_rdata, 36'h0_0000_0000);
    global_reset_n = 1'b1;
  endtask : s_resets
  task automatic s_fifo;
    mode = bram_pkg::MODE_FIFO;
    output_pipe_b = 1'b0;
    a_byte_en = 4'hf;
    for (int i = 0; i < 512; i++) begin
      push_req = 1'b1;
      a_wdata = 36'(i);
      @(negedge core_clk);
    end
    push_req = 1'b0;
    chk({34'h0, fifo_full, fifo_almost_full}, 36'h0_0000_0003);
    chk({26'h0, fifo_count}, 36'h0_0000_0200);
    ignore_flags = 1'b1;
    push_req = 1'b1;
    @(negedge core_clk);
    push_req = 1'b0;
    chk({26'h0, fifo_count}, 36'h0_0000_0200);
    ignore_flags = 1'b0;
    for (int i = 0; i < 512; i++) begin
      pop_req = 1'b1;
      @(negedge core_clk);
      pop_req = 1'b0;
      @(negedge core_clk);
      chk(b_rdata, 36'(i));
    end
    chk({34'h0, fifo_empty, fifo_almost_empty}, 36'h0_0000_0003);
    ignore_flags = 1'b1;
    pop_req = 1'b1;
    @(negedge core_clk);
    pop_req = 1'b0;
    chk({26'h0, fifo_count}, 36'h0_0000_0000);
  endtask : s_fifo
  // ****************
  // sequence
  // ****************
  initial begin
    {rst_b, ecc_enable, output_pipe_a, output_pipe_b, reset_async, tb_a_en, b_req, a_we, b_we} = 9'h000;
    {port_a_output_reset, port_b_output_reset, init_we, push_req, pop_req, ignore_flags} = 6'h00;
    global_reset_n = 1'b1;
    mode = bram_pkg::MODE_SINGLE;
    port_a_width = bram_pkg::WIDTH_36;
    port_b_width = bram_pkg::WIDTH_36;
    {a_addr, b_addr, init_addr} = 37'h0;
    {a_wdata, b_wdata, init_data} = 108'h0;
    a_byte_en = 4'hf;
    b_byte_en = 4'hf;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({35'h0, fifo_empty}, 36'h0_0000_0001);
    s_bytes();
    s_order();
    output_pipe_a = 1'b0;
    s_ecc(32'h1357_9bde, 36'h0_0000_0002);
    s_ecc(32'h1357_9bdc, 36'h0_0000_0001);
    s_rom();
    s_resets();
    s_fifo();
    complete_run();
  end
  initial begin
    repeat (10000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
endmodule : testbench
